// >>> verilog/hmr_pkg.sv
// package of constants for the host message responder
package hmr_pkg;

  // ------------------------------------------------------------
  // request kinds from the link layer
  // ------------------------------------------------------------
  localparam logic [2:0] HMR_KIND_GET_CFG0 = 3'h0;
  localparam logic [2:0] HMR_KIND_SET_DAC  = 3'h1;
  localparam logic [2:0] HMR_KIND_GET_DAC  = 3'h2;
  localparam logic [2:0] HMR_KIND_STATUS0  = 3'h3;
  localparam logic [2:0] HMR_KIND_STATUS1  = 3'h4;

  // ------------------------------------------------------------
  // first-byte message codes and flag positions
  // ------------------------------------------------------------
  localparam logic [7:0] HMR_CODE_GET_CFG0 = 8'h02;
  localparam logic [7:0] HMR_CODE_SET_DAC  = 8'h03;
  localparam logic [7:0] HMR_CODE_GET_DAC  = 8'h04;
  localparam logic [7:0] HMR_CODE_STATUS0  = 8'h05;
  localparam logic [7:0] HMR_CODE_STATUS1  = 8'h06;
  localparam logic [7:0] HMR_CODE_NONE     = 8'h00;
  localparam int         HMR_ACK_BIT       = 6;
  localparam int         HMR_UNSOL_BIT     = 7;

  // ------------------------------------------------------------
  // driver_protection_config field positions and reset
  // ------------------------------------------------------------
  localparam int         HMR_CFG_RSVD_BIT   = 7;
  localparam int         HMR_CFG_PUKEEP_BIT = 6;
  localparam int         HMR_CFG_SLEEP_BIT  = 5;
  localparam int         HMR_CFG_NEUSIM_BIT = 4;
  localparam int         HMR_CFG_UVDIS_BIT  = 3;
  localparam int         HMR_CFG_OCDIS_BIT  = 2;
  localparam int         HMR_CFG_THR_MSB    = 1;
  localparam int         HMR_CFG_THR_LSB    = 0;
  localparam logic [7:0] HMR_CFG_WR_MASK    = 8'h7f;
  localparam logic [7:0] HMR_CFG_RESET      = 8'h00;

  // ------------------------------------------------------------
  // current_limit_reference: code, step and offset
  // ------------------------------------------------------------
  localparam logic [7:0] HMR_DAC_RESET      = 8'h00;
  localparam int         HMR_DAC_STEP_UV    = 13770;
  localparam int         HMR_DAC_OFFSET_MV  = 991;

  // ------------------------------------------------------------
  // driver_fault_flags bit positions
  // ------------------------------------------------------------
  localparam int         HMR_ST1_XUVLO_BIT  = 2;
  localparam int         HMR_ST1_XOC_BIT    = 3;
  localparam int         HMR_ST1_BOR_BIT    = 4;
  localparam int         HMR_ST1_LDO_BIT    = 5;
  localparam logic       HMR_BOR_RESET      = 1'b1;
  localparam logic [7:0] HMR_ST_NORMAL      = 8'h00;

endpackage

// >>> verilog/hmr_msg_encode.sv
// two-byte message encoder for the host message responder
`timescale 1ns/1ps
module hmr_msg_encode
(
  input  wire logic [2:0] kind_i,
  input  wire logic       ack_i,
  input  wire logic       unsol_i,
  input  wire logic [7:0] cfg_i,
  input  wire logic [7:0] dac_i,
  input  wire logic [7:0] st0_i,
  input  wire logic [7:0] st1_i,
  output logic      [7:0] byte0_o,
  output logic      [7:0] byte1_o
);

  // ------------------------------------------------------------
  // base code lookup
  // ------------------------------------------------------------
  function automatic logic [7:0] hmr_base_code(input logic [2:0] kind);
    logic [7:0] code;
    code = hmr_pkg::HMR_CODE_NONE;
    unique case (kind)
      hmr_pkg::HMR_KIND_GET_CFG0: code = hmr_pkg::HMR_CODE_GET_CFG0;
      hmr_pkg::HMR_KIND_SET_DAC:  code = hmr_pkg::HMR_CODE_SET_DAC;
      hmr_pkg::HMR_KIND_GET_DAC:  code = hmr_pkg::HMR_CODE_GET_DAC;
      hmr_pkg::HMR_KIND_STATUS0:  code = hmr_pkg::HMR_CODE_STATUS0;
      hmr_pkg::HMR_KIND_STATUS1:  code = hmr_pkg::HMR_CODE_STATUS1;
      default:                    code = hmr_pkg::HMR_CODE_NONE;
    endcase
    return code;
  endfunction

  always_comb
  begin
    byte0_o                         = hmr_base_code(kind_i);
    byte0_o[hmr_pkg::HMR_ACK_BIT]   = ack_i & ~unsol_i;
    byte0_o[hmr_pkg::HMR_UNSOL_BIT] = unsol_i;
    unique case (kind_i)
      hmr_pkg::HMR_KIND_GET_CFG0: byte1_o = cfg_i & hmr_pkg::HMR_CFG_WR_MASK;
      hmr_pkg::HMR_KIND_SET_DAC:  byte1_o = dac_i;
      hmr_pkg::HMR_KIND_GET_DAC:  byte1_o = dac_i;
      hmr_pkg::HMR_KIND_STATUS0:  byte1_o = st0_i;
      hmr_pkg::HMR_KIND_STATUS1:  byte1_o = st1_i;
      default:                    byte1_o = hmr_pkg::HMR_ST_NORMAL;
    endcase
  end

endmodule

// >>> verilog/hmr_responder.sv
// host message responder: response and unsolicited message builder
`timescale 1ns/1ps
module hmr_responder
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // request from link layer
  input  wire logic       req_valid_i,
  input  wire logic [2:0] req_kind_i,
  input  wire logic       req_accept_i,
  input  wire logic [7:0] req_data_i,
  output logic            req_ready_o,
  // configuration load from link layer
  input  wire logic       cfg_load_i,
  input  wire logic [7:0] cfg_data_i,
  // fault sources
  input  wire logic [7:0] supply_fault_i,
  input  wire logic       xfet_undervoltage_lockout_i,
  input  wire logic       xfet_oc_i,
  input  wire logic       ldo_undervoltage_lockout_i,
  input  wire logic       brownout_i,
  // outgoing message to link layer
  output logic            msg_valid_o,
  input  wire logic       msg_ready_i,
  output logic      [7:0] msg_byte0_o,
  output logic      [7:0] msg_byte1_o,
  // configuration outputs
  output logic            pu_disc_en_o,
  output logic            sleep_sel_o,
  output logic            neutral_sim_en_o,
  output logic            undervoltage_lockout_dis_o,
  output logic            xoc_dis_o,
  output logic      [1:0] xoc_thr_o,
  output logic      [7:0] dac_code_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic
  {
    HMR_IDLE,
    HMR_SEND
  } hmr_state_t;

  typedef struct packed
  {
    hmr_state_t state;
    logic       req_ready;
    logic       msg_valid;
    logic [7:0] msg_byte0;
    logic [7:0] msg_byte1;
    logic [7:0] cfg;
    logic [7:0] dac;
    logic       bor;
    logic [7:0] st0_prev;
    logic [7:0] st1_prev;
    logic       pend0;
    logic       pend1;
    logic       pu_disc_en;
  } hmr_regs_t;

  hmr_regs_t  q_r;
  hmr_regs_t  q_nxt;

  logic [7:0] st0_now;
  logic [7:0] st1_now;
  logic [2:0] enc_kind;
  logic       enc_ack;
  logic       enc_unsol;
  logic [7:0] enc_dac;
  logic [7:0] enc_byte0;
  logic [7:0] enc_byte1;
  logic       take_req;
  logic       dac_wr;
  logic       report_slot;
  logic       rise0;
  logic       rise1;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // true when any flag went from clear to set since the last edge
  function automatic logic hmr_any_rise(input logic [7:0] now_flags,
                                        input logic [7:0] prev_flags);
    return |(now_flags & ~prev_flags);
  endfunction

  // ------------------------------------------------------------
  // live status payloads
  // ------------------------------------------------------------
  // status zero flags
  assign st0_now = supply_fault_i;

  always_comb
  begin
    // reserved status one bits stay zero
    st1_now                             = hmr_pkg::HMR_ST_NORMAL;
    st1_now[hmr_pkg::HMR_ST1_XUVLO_BIT] = xfet_undervoltage_lockout_i;
    st1_now[hmr_pkg::HMR_ST1_XOC_BIT]   = xfet_oc_i;
    st1_now[hmr_pkg::HMR_ST1_LDO_BIT]   = ldo_undervoltage_lockout_i;
    st1_now[hmr_pkg::HMR_ST1_BOR_BIT]   = q_r.bor;
  end

  // ------------------------------------------------------------
  // encoder selection
  // ------------------------------------------------------------
  // solicited answers go first; a pending report waits for idle
  assign take_req = (q_r.state == HMR_IDLE) & req_valid_i;
  assign dac_wr   = take_req & req_accept_i & (req_kind_i == hmr_pkg::HMR_KIND_SET_DAC);

  always_comb
  begin
    enc_kind  = req_kind_i;
    enc_ack   = req_accept_i;
    enc_unsol = 1'b0;
    if (!req_valid_i)
    begin
      enc_ack   = 1'b0;
      enc_unsol = 1'b1;
      enc_kind  = q_r.pend0 ? hmr_pkg::HMR_KIND_STATUS0 : hmr_pkg::HMR_KIND_STATUS1;
    end
  end

  // echo the new code on an accepted write
  assign enc_dac = dac_wr ? req_data_i : q_r.dac;

  hmr_msg_encode u_encode
  (
    .kind_i  (enc_kind),
    .ack_i   (enc_ack),
    .unsol_i (enc_unsol),
    .cfg_i   (q_r.cfg),
    .dac_i   (enc_dac),
    .st0_i   (st0_now),
    .st1_i   (st1_now),
    .byte0_o (enc_byte0),
    .byte1_o (enc_byte1)
  );

  // ------------------------------------------------------------
  // report queue events
  // ------------------------------------------------------------
  // idle with no request: the only slot a queued report may use
  assign report_slot = (q_r.state == HMR_IDLE) & ~req_valid_i;
  // only a rising flag queues a report; clearing stays silent,
  // so a flag that toggles fast may be folded into one report
  assign rise0       = hmr_any_rise(st0_now, q_r.st0_prev);
  assign rise1       = hmr_any_rise(st1_now, q_r.st1_prev);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    q_nxt          = q_r;
    q_nxt.st0_prev = st0_now;
    q_nxt.st1_prev = st1_now;

    if (cfg_load_i)
    begin
      q_nxt.cfg = cfg_data_i & hmr_pkg::HMR_CFG_WR_MASK;
    end

    if (dac_wr)
    begin
      q_nxt.dac = req_data_i;
    end

    q_nxt.bor = (q_r.bor & ~cfg_load_i) | brownout_i;

    // bytes latched at issue stay put however long the link stalls
    unique case (q_r.state)
      HMR_IDLE:
      begin
        if (req_valid_i)
        begin
          q_nxt.msg_valid = 1'b1;
          q_nxt.msg_byte0 = enc_byte0;
          q_nxt.msg_byte1 = enc_byte1;
          q_nxt.state     = HMR_SEND;
        end
        else if (q_r.pend0 | q_r.pend1)
        begin
          q_nxt.msg_valid = 1'b1;
          q_nxt.msg_byte0 = enc_byte0;
          q_nxt.msg_byte1 = enc_byte1;
          q_nxt.state     = HMR_SEND;
        end
      end
      HMR_SEND:
      begin
        if (msg_ready_i)
        begin
          q_nxt.msg_valid = 1'b0;
          q_nxt.state     = HMR_IDLE;
        end
      end
    endcase

    // an issued report leaves the queue; a new rise in that cycle wins
    if (report_slot & q_r.pend0)
    begin
      q_nxt.pend0 = 1'b0;
    end
    else if (report_slot & q_r.pend1)
    begin
      q_nxt.pend1 = 1'b0;
    end
    if (rise0)
    begin
      q_nxt.pend0 = 1'b1;
    end
    if (rise1)
    begin
      q_nxt.pend1 = 1'b1;
    end

    // registered from the next state, so ready falls with the taking edge
    q_nxt.req_ready = (q_nxt.state == HMR_IDLE);

    q_nxt.pu_disc_en = ~q_nxt.cfg[hmr_pkg::HMR_CFG_PUKEEP_BIT]
                     | q_nxt.cfg[hmr_pkg::HMR_CFG_SLEEP_BIT];
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      q_r.state      <= HMR_IDLE;
      q_r.req_ready  <= 1'b1;
      q_r.msg_valid  <= 1'b0;
      q_r.msg_byte0  <= hmr_pkg::HMR_CODE_NONE;
      q_r.msg_byte1  <= hmr_pkg::HMR_ST_NORMAL;
      q_r.cfg        <= hmr_pkg::HMR_CFG_RESET;
      q_r.dac        <= hmr_pkg::HMR_DAC_RESET;
      // start-up config lost
      // comes up set so the first report tells the host to reconfigure
      q_r.bor        <= hmr_pkg::HMR_BOR_RESET;
      q_r.st0_prev   <= hmr_pkg::HMR_ST_NORMAL;
      q_r.st1_prev   <= hmr_pkg::HMR_ST_NORMAL;
      q_r.pend0      <= 1'b0;
      q_r.pend1      <= 1'b0;
      q_r.pu_disc_en <= 1'b1;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign req_ready_o      = q_r.req_ready;
  assign msg_valid_o      = q_r.msg_valid;
  assign msg_byte0_o      = q_r.msg_byte0;
  assign msg_byte1_o      = q_r.msg_byte1;
  assign pu_disc_en_o     = q_r.pu_disc_en;
  assign sleep_sel_o      = q_r.cfg[hmr_pkg::HMR_CFG_SLEEP_BIT];
  assign neutral_sim_en_o = q_r.cfg[hmr_pkg::HMR_CFG_NEUSIM_BIT];
  assign undervoltage_lockout_dis_o       = q_r.cfg[hmr_pkg::HMR_CFG_UVDIS_BIT];
  assign xoc_dis_o        = q_r.cfg[hmr_pkg::HMR_CFG_OCDIS_BIT];
  assign xoc_thr_o        = q_r.cfg[hmr_pkg::HMR_CFG_THR_MSB:hmr_pkg::HMR_CFG_THR_LSB];
  // passed as is: every eight-bit code is a legal reference step
  assign dac_code_o       = q_r.dac;

endmodule

// >>> verif/hmr_responder_props.sv
// assertion checker for the host message responder
`timescale 1ns/1ps
module hmr_responder_props
(
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic       req_valid_i,
  input wire logic [2:0] req_kind_i,
  input wire logic       req_accept_i,
  input wire logic [7:0] req_data_i,
  input wire logic       req_ready_o,
  input wire logic       cfg_load_i,
  input wire logic [7:0] cfg_data_i,
  input wire logic       msg_valid_o,
  input wire logic       msg_ready_i,
  input wire logic [7:0] msg_byte0_o,
  input wire logic [7:0] msg_byte1_o,
  input wire logic       pu_disc_en_o,
  input wire logic       sleep_sel_o,
  input wire logic       neutral_sim_en_o,
  input wire logic       undervoltage_lockout_dis_o,
  input wire logic       xoc_dis_o,
  input wire logic [1:0] xoc_thr_o,
  input wire logic [7:0] dac_code_o
);
  // --------------------------------------------------
  // expected first byte of a taken request
  // --------------------------------------------------
  logic       take;
  logic [7:0] ce;
  assign take = req_valid_i && req_ready_o;
  always_comb
  begin
    case (req_kind_i)
      hmr_pkg::HMR_KIND_GET_CFG0: ce = hmr_pkg::HMR_CODE_GET_CFG0;
      hmr_pkg::HMR_KIND_SET_DAC:  ce = hmr_pkg::HMR_CODE_SET_DAC;
      hmr_pkg::HMR_KIND_GET_DAC:  ce = hmr_pkg::HMR_CODE_GET_DAC;
      hmr_pkg::HMR_KIND_STATUS0:  ce = hmr_pkg::HMR_CODE_STATUS0;
      default:                    ce = hmr_pkg::HMR_CODE_STATUS1;
    endcase
    ce[6] = req_accept_i;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // --------------------------------------------------
  // properties
  // --------------------------------------------------
  answer_next_a: assert property (take |=> msg_valid_o && !req_ready_o)
    else $error("no message after a taken request");
  first_byte_a: assert property (take |=> msg_byte0_o == $past(ce))
    else $error("wrong response code");
  msg_hold_a: assert property (msg_valid_o && !msg_ready_i |=>
    msg_valid_o && $stable(msg_byte0_o) && $stable(msg_byte1_o))
    else $error("message changed before handover");
  handoff_a: assert property (msg_valid_o && msg_ready_i |=> !msg_valid_o)
    else $error("message stayed after handover");
  cfg_rsvd_a: assert property (msg_valid_o && msg_byte0_o[5:0] == 6'h02 |-> !msg_byte1_o[7])
    else $error("config reserved bit set");
  pu_disc_a: assert property (cfg_load_i |=>
    pu_disc_en_o == $past(!cfg_data_i[6] || cfg_data_i[5]))
    else $error("pull-up disconnect wrong");
  cfg_fields_a: assert property (cfg_load_i |=>
    {sleep_sel_o, neutral_sim_en_o, undervoltage_lockout_dis_o, xoc_dis_o, xoc_thr_o} == $past(cfg_data_i[5:0]))
    else $error("config outputs wrong");
  dac_set_a: assert property (take && req_kind_i == 3'h1 && req_accept_i |=>
    dac_code_o == $past(req_data_i) && msg_byte1_o == dac_code_o)
    else $error("dac code not taken");
  dac_keep_a: assert property (take && req_kind_i == 3'h1 && !req_accept_i |=>
    $stable(dac_code_o) && msg_byte1_o == dac_code_o)
    else $error("rejected dac write changed code");
  st1_rsvd_a: assert property (msg_valid_o && msg_byte0_o[5:0] == 6'h06 |->
    (msg_byte1_o & 8'hc3) == 8'h00)
    else $error("status one reserved bit set");
  unsol_code_a: assert property (msg_valid_o && msg_byte0_o[7] |->
    !msg_byte0_o[6] && (msg_byte0_o[5:0] == 6'h05 || msg_byte0_o[5:0] == 6'h06))
    else $error("bad unsolicited code");
  cover property (take && req_kind_i == 3'h1 && req_accept_i);
  cover property (msg_valid_o && msg_byte0_o == 8'h86);
  cover property (msg_valid_o && msg_byte0_o == 8'h85);
  cover property (msg_valid_o && !msg_ready_i);
endmodule
bind hmr_responder hmr_responder_props i_hmr_responder_props (.*);

// >>> verif/hmr_host_model.sv
// host side model: takes messages, stalls at random, decodes the code byte
`timescale 1ns/1ps
module hmr_host_model
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       slow_i,
  input  wire logic       msg_valid_i,
  input  wire logic [7:0] msg_byte0_i,
  output logic            msg_ready_o,
  output logic      [1:0] msg_class_o
);
  int seed = 50245;
  // random stalls only while slow mode asks for them
  always @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
      msg_ready_o <= 1'b0;
    else
      msg_ready_o <= slow_i ? $random(seed) % 2 != 0 : 1'b1;
  always @(posedge mclk_i)
    if (msg_valid_i && msg_ready_o)
      msg_class_o <= {msg_byte0_i[7], msg_byte0_i[6]};
endmodule

// >>> verif/hmr_responder_test.sv
// self-checking bench for the host message responder
`timescale 1ns/1ps
module hmr_responder_test;
  logic        mclk_i = 1'b0, sys_rst_i = 1'b1, slow = 1'b0;
  logic        req_valid_i = 1'b0, req_accept_i = 1'b0, cfg_load_i = 1'b0;
  logic        xfet_undervoltage_lockout_i = 1'b0, xfet_oc_i = 1'b0, ldo_undervoltage_lockout_i = 1'b0, brownout_i = 1'b0;
  logic [2:0]  req_kind_i = 3'h0;
  logic [7:0]  req_data_i = 8'h00, cfg_data_i = 8'h00, supply_fault_i = 8'h00;
  logic        req_ready_o, msg_valid_o, msg_ready_i, pu_disc_en_o, sleep_sel_o;
  logic        neutral_sim_en_o, undervoltage_lockout_dis_o, xoc_dis_o, bor_m = 1'b1, cls_due = 1'b0;
  logic [1:0]  xoc_thr_o, cls, cls_w;
  logic [7:0]  msg_byte0_o, msg_byte1_o, dac_code_o, cfg_m = 8'h00, dac_m = 8'h00;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [3:0]  v;
  int          num_errors = 0, n_compared = 0, seed = 50245, n;
  always #2.5 mclk_i = ~mclk_i;
  hmr_responder i_hmr_responder (.*);
  hmr_host_model i_hmr_host_model (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
    .msg_valid_i(msg_valid_o), .msg_byte0_i(msg_byte0_o), .msg_ready_o(msg_ready_i),
    .msg_class_o(cls));
  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] st1m;
    return {2'b00, ldo_undervoltage_lockout_i, bor_m, xfet_oc_i, xfet_undervoltage_lockout_i, 2'b00};
  endfunction
  task automatic cfgchk(input logic [7:0] c);
    check({1'b0, pu_disc_en_o, sleep_sel_o, neutral_sim_en_o, undervoltage_lockout_dis_o, xoc_dis_o,
      xoc_thr_o}, {1'b0, ~c[6] | c[5], c[5:0]});
  endtask
  task automatic load(input logic [7:0] c);
    @(posedge mclk_i);
    cfg_load_i <= 1'b1;
    cfg_data_i <= c;
    @(posedge mclk_i);
    cfg_load_i <= 1'b0;
    cfg_m = c & 8'h7f;
    bor_m = brownout_i;
    #1 cfgchk(c);
  endtask
  // request held until taken; payload noted at the taking edge
  task automatic send(input logic [2:0] k, input logic a, input logic [7:0] d);
    logic [7:0] pl;
    @(posedge mclk_i);
    req_kind_i <= k;
    req_accept_i <= a;
    req_data_i <= d;
    req_valid_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (req_ready_o !== 1'b1 && n < 60);
    req_valid_i <= 1'b0;
    if (n >= 60)
    begin
      num_errors++;
      conclude();
    end
    if (k == 3'h1 && a)
      dac_m = d;
    case (k)
      3'h0: pl = cfg_m;
      3'h1, 3'h2: pl = dac_m;
      3'h3: pl = supply_fault_i;
      default: pl = st1m();
    endcase
    exp_q.push_back({{1'b0, a, 6'h00} | (8'h02 + {5'h00, k}), pl});
  endtask
  // ------------------------------------------------
  // output watcher
  // ------------------------------------------------
  always @(posedge mclk_i)
  begin
    // host class lands one edge after the handover
    if (cls_due)
      check({6'h00, cls}, {6'h00, cls_w});
    cls_due = 1'b0;
    if (!sys_rst_i && msg_valid_o === 1'b1 && msg_ready_i === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      check(msg_byte0_o, e[15:8]);
      check(msg_byte1_o, e[7:0]);
      cls_w = e[15:14];
      cls_due = 1'b1;
    end
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    exp_q.push_back({8'h86, 8'h10});
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    cfgchk(8'h00);
    check(dac_code_o, 8'h00);
    send(3'h4, 1'b1, 8'h00);
    slow <= 1'b1;
    repeat (4)
    begin
      load(8'($random(seed)));
      for (int k = 0; k < 5; k++)
        for (int a = 0; a < 2; a++)
          send(k[2:0], a[0], 8'($random(seed)));
    end
    v = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk_i);
      v[i] = 1'b1;
      {ldo_undervoltage_lockout_i, brownout_i, xfet_oc_i, xfet_undervoltage_lockout_i} <= v;
      bor_m = bor_m | v[2];
      @(posedge mclk_i);
      exp_q.push_back({8'h86, st1m()});
      repeat (30) @(posedge mclk_i);
    end
    @(posedge mclk_i);
    supply_fault_i <= 8'($random(seed)) | 8'h01;
    @(posedge mclk_i);
    exp_q.push_back({8'h85, supply_fault_i});
    repeat (30) @(posedge mclk_i);
    send(3'h3, 1'b1, 8'h00);
    send(3'h4, 1'b0, 8'h00);
    {ldo_undervoltage_lockout_i, brownout_i, xfet_oc_i, xfet_undervoltage_lockout_i, supply_fault_i} <= 12'h000;
    load(8'h25);
    send(3'h4, 1'b1, 8'h00);
    send(3'h3, 1'b0, 8'h00);
    n = 0;
    while (exp_q.size() > 0 && n < 200)
    begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 200)
      num_errors++;
    conclude();
  end
endmodule
